// ===== shared/fgr_cfg.svh
// What this block does
// - Fast-gate port answers reads and writes only while config bit 2 enables it.
// - Fast-gate reads return 00 in bits 7:6, 1 in 5, 0 in 4:3, 1 in 2.
// - Bit 1 written 0 drives alternate A20 low; written 1 drives it high.
// - Bit 0 is the readable, writable reset request, cleared by system reset.
// - Writing 1 to bit 0 pulses fast reset low 7us, starting 15us later.
// - No further pulse until bit 0 returns to 0 by reset or write.
// - On reset the fast reset output is high and bit 0 reads 0.
// - When enabled, fast reset ANDs with controller reset onto keyboard reset pin.
// - Address-20 gate is low only when controller gate and alternate A20 are low.
// - On reset the alternate A20 control is driven low.
// - Config bit 4 selects mouse irq: raw AND latched, or latched alone.
// - Config bit 3 selects keyboard irq: raw AND latched, or latched alone.
// - The controller port pin serves as software address-20 gate into the OR.
`ifndef FGR_CFG_SVH
`define FGR_CFG_SVH

// register locations: fast gate in i/o space, config in logical-device config space
`define FGR_FAST_GATE_ADDR 8'h92
`define FGR_CFG_ADDR 8'hF0

// fast gate register layout
`define FGR_FG_RST_BIT 0
`define FGR_FG_A20_BIT 1
`define FGR_FG_FIXED_MASK 8'hFC
`define FGR_FG_FIXED_VAL 8'h24
`define FGR_FG_RESET 8'h24

// config register layout
`define FGR_CFG_EN_BIT 2
`define FGR_CFG_KBD_IRQ_LATCH_SEL_BIT 3
`define FGR_CFG_MOUSE_IRQ_LATCH_SEL_BIT 4
`define FGR_CFG_RESET 8'h00

// value returned for a read of a register that is not answering
`define FGR_FLOAT_READ 8'hFF

// timing of the fast reset pulse
`define FGR_CLK_PERIOD_PS 4000
`define FGR_RST_DELAY_NS 15000
`define FGR_RST_WIDTH_NS 7000
`define FGR_RST_DELAY_CYC (((`FGR_RST_DELAY_NS * 1000) + `FGR_CLK_PERIOD_PS - 1) / `FGR_CLK_PERIOD_PS)
`define FGR_RST_WIDTH_CYC (((`FGR_RST_WIDTH_NS * 1000) + `FGR_CLK_PERIOD_PS - 1) / `FGR_CLK_PERIOD_PS)

`endif

// ===== shared/fgr_pkg.sv
package fgr_pkg;

    // one host access, presented for a single cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic cfg_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fgr_io_req_t;

    // read answer, one cycle after the read strobe
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } fgr_io_rsp_t;

    // raw and cleared controller interrupt inputs
    typedef struct packed {
        logic kbd_irq_raw;
        logic mouse_irq_raw;
        logic kbd_irq_clr;
        logic mouse_irq_clr;
    } fgr_irq_in_t;

    // fast reset pulse sequencer
    typedef enum logic [3:0] {
        FGR_ST_IDLE = 4'b0001,
        FGR_ST_DELAY = 4'b0010,
        FGR_ST_PULSE = 4'b0100,
        FGR_ST_DONE = 4'b1000
    } fgr_rst_state_t;

endpackage

// ===== hdl/fgr_irq_latch.sv
`timescale 1ns/1ps
`include "fgr_cfg.svh"

module fgr_irq_latch
(
    // clock and reset
    input logic core_clk,
    input logic nrst,
    // controller side
    input logic irq_raw,
    input logic irq_clr,
    input logic latch_sel,
    // output to system
    output logic irq_out
);
    logic raw_q;
    logic raw_d;
    logic held_q;
    logic held_d;
    logic out_q;
    logic out_d;

    // catch the rising edge; the edge wins over a clear in the same cycle
    always_comb
    begin
        raw_d = irq_raw;
        held_d = held_q;
        if (irq_clr)
        begin
            held_d = 1'b0;
        end
        if (irq_raw && !raw_q)
        begin
            held_d = 1'b1;
        end
        out_d = latch_sel ? held_d : (irq_raw & held_d);
    end

    // register the latch and the selected output
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            raw_q <= 1'b0;
            held_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            raw_q <= raw_d;
            held_q <= held_d;
            out_q <= out_d;
        end
    end

    assign irq_out = out_q;

endmodule // fgr_irq_latch

// ===== hdl/fgr_top.sv
`timescale 1ns/1ps
`include "fgr_cfg.svh"

module fgr_top
#(
    parameter int DELAY_CYC = `FGR_RST_DELAY_CYC,
    parameter int WIDTH_CYC = `FGR_RST_WIDTH_CYC
)
(
    // clock and reset
    input logic core_clk,
    input logic nrst,
    // host i/o access
    input fgr_pkg::fgr_io_req_t io_req,
    output fgr_pkg::fgr_io_rsp_t io_rsp,
    // keyboard controller signals
    input logic kbd_ctrl_reset_n,
    input logic ctrl_port_pin_addr20,
    input fgr_pkg::fgr_irq_in_t irq_in,
    // pin polarity configuration of the keyboard reset pin
    input logic kbd_reset_pol_inv,
    // system outputs
    output logic alt_addr20_ctl,
    output logic fast_cpu_reset_n,
    output logic addr20_gate_out,
    output logic kbd_reset_out,
    output logic kbd_irq,
    output logic mouse_irq,
    // enable bit of the config register
    output logic kbd_reset_gate_cfg_en
);
    import fgr_pkg::*;

    // counter wide enough for either interval; the delay load is the larger
    // one, so this width sets the fastest clock the block can serve
    localparam int CNT_W = 16;

    // access decode shared by read and write paths
    // the space select keeps config and i/o decodes apart even if their
    // offsets were ever to coincide
    function automatic logic hit(input fgr_io_req_t r, input logic cfg, input logic [7:0] a);
        hit = (r.cfg_sel == cfg) && (r.addr == a);
    endfunction

    // register state
    // port_en mirrors the enable bit so every decode uses one name
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic rst_req_q;
    logic rst_req_d;
    logic a20_q;
    logic a20_d;
    logic port_en;
    logic fg_wr;
    logic fg_rd;
    logic cfg_wr;
    logic cfg_rd;
    logic set_pulse;

    // read answer state
    // ack and data travel together in one registered struct
    fgr_io_rsp_t rsp_q;
    fgr_io_rsp_t rsp_d;

    // pulse sequencer state
    // one-hot codes keep the next-state decode shallow
    fgr_rst_state_t st_q;
    fgr_rst_state_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic fast_n_q;
    logic fast_n_d;

    // output registers
    // combined_n is the reset level before the pin polarity is applied
    logic gate_q;
    logic gate_d;
    logic kbd_reset_out_q;
    logic kbd_reset_out_d;
    logic combined_n;

    // strobes; the fast-gate port answers only when enabled
    // a disabled port neither stores a write nor drives read data, so a host
    // that forgets the enable sees a floating bus rather than stale contents
    always_comb
    begin
        port_en = cfg_q[`FGR_CFG_EN_BIT];
        fg_wr = io_req.wr && port_en && hit(io_req, 1'b0, `FGR_FAST_GATE_ADDR);
        fg_rd = io_req.rd && port_en && hit(io_req, 1'b0, `FGR_FAST_GATE_ADDR);
        cfg_wr = io_req.wr && hit(io_req, 1'b1, `FGR_CFG_ADDR);
        cfg_rd = io_req.rd && hit(io_req, 1'b1, `FGR_CFG_ADDR);
    end

    // register writes; reserved fast-gate bits are not stored
    // only bits 1 and 0 hold state: the reserved positions are rebuilt from
    // constants on every read, so no write can ever disturb them
    // the config register keeps all eight bits so software can read back
    // its own latch and enable settings
    // writes to the two spaces never collide, the space select keeps them apart
    always_comb
    begin
        cfg_d = cfg_q;
        rst_req_d = rst_req_q;
        a20_d = a20_q;
        if (cfg_wr)
        begin
            cfg_d = io_req.wdata;
        end
        if (fg_wr)
        begin
            rst_req_d = io_req.wdata[`FGR_FG_RST_BIT];
            a20_d = io_req.wdata[`FGR_FG_A20_BIT];
        end
    end

    // a pulse starts only on a 0 to 1 change of the request bit
    // writing 1 again while the bit already reads 1 must not restart the
    // sequencer, otherwise a polling loop could keep the processor in reset
    // a write that only changes bit 1 therefore never disturbs a pulse
    assign set_pulse = fg_wr && io_req.wdata[`FGR_FG_RST_BIT] && !rst_req_q;

    // read data: fixed reserved bits plus the two live bits
    // every read is answered the next cycle, even an unmapped or disabled one,
    // so the host never waits; such reads return the floating-bus value
    // the live bits come from the registers, so a read shows a write at once
    always_comb
    begin
        rsp_d.ack = io_req.rd;
        rsp_d.rdata = `FGR_FLOAT_READ;
        if (fg_rd)
        begin
            rsp_d.rdata = `FGR_FG_FIXED_VAL & `FGR_FG_FIXED_MASK;
            rsp_d.rdata[`FGR_FG_A20_BIT] = a20_q;
            rsp_d.rdata[`FGR_FG_RST_BIT] = rst_req_q;
        end
        else if (cfg_rd)
        begin
            rsp_d.rdata = cfg_q;
        end
    end

    // registers and read answer
    // the request bit clears on system reset, so a warm start never re-fires
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cfg_q <= `FGR_CFG_RESET;
            rst_req_q <= 1'(`FGR_FG_RESET & 8'h01);
            a20_q <= 1'b0;
            rsp_q <= '0;
        end
        else
        begin
            cfg_q <= cfg_d;
            rst_req_q <= rst_req_d;
            a20_q <= a20_d;
            rsp_q <= rsp_d;
        end
    end

    // fast reset sequencer: wait, pulse low, then hold off until bit 0 is cleared
    // the counter is loaded with one less than the interval because the
    // state change itself uses up a cycle; the delay thus starts at the
    // taking edge and the low time covers exactly the programmed cycles
    // writing 0 while the pulse runs does not shorten it: the processor
    // must always see a full-width reset or it may come out half reset
    // a request while busy is not queued; the host must clear and set again
    // once the sequencer has come back to idle
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        fast_n_d = 1'b1;
        case (st_q)
            // idle: wait for a fresh request
            FGR_ST_IDLE:
            begin
                if (set_pulse)
                begin
                    st_d = FGR_ST_DELAY;
                    cnt_d = CNT_W'(DELAY_CYC - 1);
                end
            end
            // delay: count down before the pulse, output still high
            FGR_ST_DELAY:
            begin
                if (cnt_q == '0)
                begin
                    st_d = FGR_ST_PULSE;
                    cnt_d = CNT_W'(WIDTH_CYC - 1);
                    fast_n_d = 1'b0;
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            // pulse: hold the output low for the programmed width
            FGR_ST_PULSE:
            begin
                if (cnt_q == '0)
                begin
                    st_d = FGR_ST_DONE;
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                    fast_n_d = 1'b0;
                end
            end
            // done: blocked until the host clears the request bit
            FGR_ST_DONE:
            begin
                if (!rst_req_q)
                begin
                    st_d = FGR_ST_IDLE;
                end
            end
            // an illegal code falls back to idle with the output high
            default:
            begin
                st_d = FGR_ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    // sequencer registers
    // the output starts high so the processor is never held in reset by us
    // counter and output move on the same edge as the state
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            st_q <= FGR_ST_IDLE;
            cnt_q <= '0;
            fast_n_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            fast_n_q <= fast_n_d;
        end
    end

    // gate and keyboard reset pin
    // the gate output is an or: either source may open address line 20,
    // and only when both are low is the line masked again
    // with the port disabled the controller reset passes alone, so an
    // unconfigured system keeps the slow controller reset path
    // the polarity flip comes last so the combined level has one meaning
    always_comb
    begin
        gate_d = ctrl_port_pin_addr20 | a20_q;
        combined_n = port_en ? (fast_n_q & kbd_ctrl_reset_n) : kbd_ctrl_reset_n;
        kbd_reset_out_d = combined_n ^ kbd_reset_pol_inv;
    end

    // output registers
    // both pins settle one cycle after their inputs change
    // reset leaves the gate closed and the keyboard reset pin high, which is inactive only without polarity inversion
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            gate_q <= 1'b0;
            kbd_reset_out_q <= 1'b1;
        end
        else
        begin
            gate_q <= gate_d;
            kbd_reset_out_q <= kbd_reset_out_d;
        end
    end

    // keyboard interrupt latch
    // edges are caught on the controller's raw line; the config bit picks
    // whether the raw level still gates the output
    // the clear input comes straight from the controller side
    fgr_irq_latch u_kbd_latch
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .irq_raw(irq_in.kbd_irq_raw),
        .irq_clr(irq_in.kbd_irq_clr),
        .latch_sel(cfg_q[`FGR_CFG_KBD_IRQ_LATCH_SEL_BIT]),
        .irq_out(kbd_irq)
    );

    // mouse interrupt latch
    // same circuit as the keyboard side, with its own select bit
    fgr_irq_latch u_mouse_latch
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .irq_raw(irq_in.mouse_irq_raw),
        .irq_clr(irq_in.mouse_irq_clr),
        .latch_sel(cfg_q[`FGR_CFG_MOUSE_IRQ_LATCH_SEL_BIT]),
        .irq_out(mouse_irq)
    );

    // flop-driven outputs
    // every output is a register, so no decode glitch reaches a pin
    // the interrupt outputs are registered inside the latch modules
    assign io_rsp = rsp_q;
    assign alt_addr20_ctl = a20_q;
    assign fast_cpu_reset_n = fast_n_q;
    assign addr20_gate_out = gate_q;
    assign kbd_reset_out = kbd_reset_out_q;
    assign kbd_reset_gate_cfg_en = cfg_q[`FGR_CFG_EN_BIT];

endmodule // fgr_top

// ===== testbench/fgr_top_assertions.sv
`timescale 1ns/1ps
module fgr_chk
import fgr_pkg::*;
#(
    parameter int DELAY_CYC = 5,
    parameter int WIDTH_CYC = 3
)
(
    // clock and reset
    input logic core_clk,
    input logic nrst,
    // host side
    input fgr_pkg::fgr_io_req_t io_req,
    input fgr_pkg::fgr_io_rsp_t io_rsp,
    // controller side
    input logic kbd_ctrl_reset_n,
    input logic ctrl_port_pin_addr20,
    input logic kbd_reset_pol_inv,
    // outputs
    input logic alt_addr20_ctl,
    input logic fast_cpu_reset_n,
    input logic addr20_gate_out,
    input logic kbd_reset_out,
    input logic kbd_reset_gate_cfg_en
);
    logic [15:0] lo_q, lo_d, dl_q, dl_d;
    logic fg_wr;
    // accepted write to the fast gate port
    assign fg_wr = io_req.wr && !io_req.cfg_sel && io_req.addr == 8'h92 && kbd_reset_gate_cfg_en;
    // low time of the pulse, and cycles since a write of the request bit
    always_comb
    begin
        lo_d = fast_cpu_reset_n ? 16'h0000 : lo_q + 16'h0001;
        dl_d = dl_q + {15'h0000, dl_q != 16'h0000 && dl_q != 16'hFFFF};
        if (fg_wr && io_req.wdata[0])
            dl_d = 16'h0001;
    end
    always_ff @(posedge core_clk)
    begin
        lo_q <= nrst ? lo_d : 16'h0000;
        dl_q <= nrst ? dl_d : 16'h0000;
    end
    AST_A20_OUT: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> addr20_gate_out == $past(ctrl_port_pin_addr20 | alt_addr20_ctl))
        else $error("gate output mismatch");
    AST_A20_WR: assert property (@(posedge core_clk) disable iff (!nrst)
        fg_wr |=> alt_addr20_ctl == $past(io_req.wdata[1])) else $error("a20 control mismatch");
    AST_KRST: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> kbd_reset_out == $past((kbd_ctrl_reset_n
        & (fast_cpu_reset_n | !kbd_reset_gate_cfg_en)) ^ kbd_reset_pol_inv))
        else $error("keyboard reset mismatch");
    AST_ACK: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> io_rsp.ack == $past(io_req.rd)) else $error("ack mismatch");
    AST_FIXED: assert property (@(posedge core_clk) disable iff (!nrst)
        io_rsp.ack && $past(!io_req.cfg_sel && io_req.addr == 8'h92 && kbd_reset_gate_cfg_en)
        |-> io_rsp.rdata[7:2] == 6'h09) else $error("fixed bits mismatch");
    AST_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
        io_rsp.ack && $past(!io_req.cfg_sel && !kbd_reset_gate_cfg_en)
        |-> io_rsp.rdata == 8'hFF) else $error("disabled read mismatch");
    AST_RST: assert property (@(posedge core_clk)
        $past(!nrst) |-> fast_cpu_reset_n && !alt_addr20_ctl) else $error("reset value mismatch");
    AST_WIDTH: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(fast_cpu_reset_n) |-> lo_q == WIDTH_CYC) else $error("pulse width mismatch");
    AST_DELAY: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(fast_cpu_reset_n) |-> dl_q > DELAY_CYC) else $error("pulse delay mismatch");
endmodule // fgr_chk
bind fgr_top fgr_chk #(.DELAY_CYC(DELAY_CYC), .WIDTH_CYC(WIDTH_CYC)) i_chk (.core_clk, .nrst,
    .io_req, .io_rsp, .kbd_ctrl_reset_n, .ctrl_port_pin_addr20, .kbd_reset_pol_inv,
    .alt_addr20_ctl, .fast_cpu_reset_n, .addr20_gate_out, .kbd_reset_out, .kbd_reset_gate_cfg_en);

// ===== testbench/fgr_host.sv
`timescale 1ns/1ps
module fgr_host
import fgr_pkg::*;
(
    // clock
    input logic core_clk,
    // host bus
    output fgr_pkg::fgr_io_req_t io_req,
    input fgr_pkg::fgr_io_rsp_t io_rsp
);
    initial io_req = '0;
    // one strobe; address and data change once it is dropped
    task automatic acc(input logic w, input logic c, input logic [7:0] a, input logic [7:0] d);
    begin
        io_req = '{wr: w, rd: !w, cfg_sel: c, addr: a, wdata: d};
        @(posedge core_clk);
        #1;
        io_req = '{wr: 1'b0, rd: 1'b0, cfg_sel: c, addr: ~a, wdata: ~d};
    end
    endtask
    // write; one strobe, then one more clock edge before returning
    task automatic wr(input logic c, input logic [7:0] a, input logic [7:0] d);
    begin
        acc(1'b1, c, a, d);
        @(posedge core_clk);
        #1;
    end
    endtask
    // read; answer taken the cycle after the strobe
    task automatic rd(input logic c, input logic [7:0] a, output logic k, output logic [7:0] d);
    begin
        acc(1'b0, c, a, 8'h00);
        k = io_rsp.ack;
        d = io_rsp.rdata;
        @(posedge core_clk);
        #1;
    end
    endtask
endmodule // fgr_host

// ===== testbench/fgr_top_tb.sv
`timescale 1ns/1ps
module fgr_top_tb;
import fgr_pkg::*;
    localparam int DLY = 5;
    localparam int WID = 3;
    logic core_clk, nrst, kbd_ctrl_reset_n, ctrl_port_pin_addr20, kbd_reset_pol_inv;
    logic alt_addr20_ctl, fast_cpu_reset_n, addr20_gate_out, kbd_reset_out, kbd_irq, mouse_irq;
    logic en, ack;
    logic [7:0] rd_d;
    fgr_io_req_t io_req;
    fgr_io_rsp_t io_rsp;
    fgr_irq_in_t irq_in;
    int bad_count, compares, n;
    fgr_top #(.DELAY_CYC(DLY), .WIDTH_CYC(WID)) i_dut (.core_clk, .nrst, .io_req, .io_rsp,
        .kbd_ctrl_reset_n, .ctrl_port_pin_addr20, .irq_in, .kbd_reset_pol_inv, .alt_addr20_ctl,
        .fast_cpu_reset_n, .addr20_gate_out, .kbd_reset_out, .kbd_irq, .mouse_irq,
        .kbd_reset_gate_cfg_en(en));
    fgr_host i_host (.core_clk, .io_req, .io_rsp);
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic wrap_up;
    begin
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task automatic chk1(input string s, input logic e, input logic v);
    begin
        compares++;
        if (v !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", s, e, v);
        end
    end
    endtask
    task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] v);
    begin
        compares++;
        if (v !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", s, e, v);
        end
    end
    endtask
    task automatic cyc(input int k);
    begin
        repeat (k) @(posedge core_clk);
        #1;
    end
    endtask
    task automatic rd8(input logic c, input logic [7:0] a, input logic [7:0] e);
    begin
        i_host.rd(c, a, ack, rd_d);
        chk1("ack", 1'b1, ack);
        chk8("rdata", e, rd_d);
    end
    endtask
    // cycles until the fast reset reaches a level, bounded
    task automatic wait_fast(input logic l);
    begin
        n = 0;
        while (fast_cpu_reset_n !== l && n < 100)
        begin
            cyc(1);
            n++;
        end
        if (n >= 100)
        begin
            bad_count++;
            wrap_up;
        end
    end
    endtask
    // main sequence
    initial
    begin
        nrst = 1'b0;
        kbd_ctrl_reset_n = 1'b1;
        ctrl_port_pin_addr20 = 1'b0;
        kbd_reset_pol_inv = 1'b0;
        irq_in = '0;
        cyc(5);
        nrst = 1'b1;
        rd8(1'b0, 8'h92, 8'hFF);
        i_host.wr(1'b0, 8'h92, 8'h03);
        chk1("alt_addr20_ctl", 1'b0, alt_addr20_ctl);
        rd8(1'b1, 8'hF0, 8'h00);
        i_host.wr(1'b1, 8'hF0, 8'h04);
        rd8(1'b1, 8'hF0, 8'h04);
        chk1("enable", 1'b1, en);
        rd8(1'b0, 8'h92, 8'h24);
        $display("test access done");
        for (int i = 0; i < 4; i++)
        begin
            i_host.wr(1'b0, 8'h92, {6'h3F, i[1], 1'b0});
            ctrl_port_pin_addr20 = i[0];
            cyc(2);
            chk1("alt_addr20_ctl", i[1], alt_addr20_ctl);
            chk1("gate out", i[0] | i[1], addr20_gate_out);
        end
        rd8(1'b0, 8'h92, 8'h26);
        $display("test gate done");
        // each count starts one edge late: the write task spends an edge after the
        // taking edge, and the keyboard reset check spends one inside the pulse
        i_host.wr(1'b0, 8'h92, 8'h01);
        wait_fast(1'b0);
        chk8("delay", 8'(DLY - 1), n[7:0]);
        cyc(1);
        chk1("kbd reset", 1'b0, kbd_reset_out);
        wait_fast(1'b1);
        chk8("width", 8'(WID - 1), n[7:0]);
        rd8(1'b0, 8'h92, 8'h25);
        i_host.wr(1'b0, 8'h92, 8'h01);
        repeat (DLY + WID + 4)
        begin
            cyc(1);
            chk1("no pulse", 1'b1, fast_cpu_reset_n);
        end
        i_host.wr(1'b0, 8'h92, 8'h00);
        i_host.wr(1'b0, 8'h92, 8'h01);
        wait_fast(1'b0);
        chk8("delay", 8'(DLY - 1), n[7:0]);
        wait_fast(1'b1);
        $display("test pulse done");
        kbd_reset_pol_inv = 1'b1;
        cyc(2);
        chk1("kbd reset", 1'b0, kbd_reset_out);
        kbd_ctrl_reset_n = 1'b0;
        cyc(2);
        chk1("kbd reset", 1'b1, kbd_reset_out);
        irq_in = 4'b1100;
        cyc(2);
        chk1("kbd irq", 1'b1, kbd_irq);
        chk1("mouse irq", 1'b1, mouse_irq);
        irq_in = 4'b0000;
        cyc(2);
        chk1("kbd irq", 1'b0, kbd_irq);
        chk1("mouse irq", 1'b0, mouse_irq);
        irq_in = 4'b0011;
        cyc(2);
        chk1("kbd irq", 1'b0, kbd_irq);
        chk1("mouse irq", 1'b0, mouse_irq);
        irq_in = 4'b0000;
        i_host.wr(1'b1, 8'hF0, 8'h1C);
        irq_in = 4'b1100;
        cyc(1);
        irq_in = 4'b0000;
        cyc(2);
        chk1("kbd irq", 1'b1, kbd_irq);
        chk1("mouse irq", 1'b1, mouse_irq);
        irq_in = 4'b0011;
        cyc(1);
        irq_in = 4'b0000;
        cyc(2);
        chk1("kbd irq", 1'b0, kbd_irq);
        chk1("mouse irq", 1'b0, mouse_irq);
        $display("test irq done");
        i_host.wr(1'b0, 8'h92, 8'h03);
        chk1("alt_addr20_ctl", 1'b1, alt_addr20_ctl);
        nrst = 1'b0;
        cyc(2);
        nrst = 1'b1;
        chk1("alt_addr20_ctl", 1'b0, alt_addr20_ctl);
        chk1("fast reset", 1'b1, fast_cpu_reset_n);
        rd8(1'b1, 8'hF0, 8'h00);
        i_host.wr(1'b1, 8'hF0, 8'h04);
        rd8(1'b0, 8'h92, 8'h24);
        $display("test reset done");
        wrap_up;
    end
endmodule // fgr_top_tb
